// ---- core/pss_pkg.sv ----
// Shared constants and types of the power-on reset sequencer
package pss_pkg;
    // Clock rate
    localparam int CLK_MHZ = 40;
    // Supply thresholds the core comparator is trimmed to, in mV
    localparam int START_MV_STD = 1700;
    localparam int START_MV_LV = 1550;
    localparam int SAG_MV = 1400;
    // Longest configuration time and the late I/O bank delay, in us
    localparam int CONFIGURATION_TIME_US = 450;
    localparam int IO_DELAY_US = 2;
    localparam int CONFIGURATION_TIME_CYC = CONFIGURATION_TIME_US * CLK_MHZ;
    localparam int IO_DELAY_CYC = IO_DELAY_US * CLK_MHZ;
    localparam int TIMER_W = 16;
    localparam int IO_BANKS = 4;
    // Register map
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam int CTRL_CLR_EN_BIT = 0;
    localparam int CTRL_OE_EN_BIT = 1;
    localparam int CTRL_RECONFIG_BIT = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_CORE_BIT = 4;
    localparam int STAT_IO_BIT = 5;
    localparam int STAT_LATE_BIT = 6;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    typedef enum logic [2:0] {
        S_OFF, S_LOAD, S_IOWAIT, S_IODLY, S_REGREL, S_USER
    } pss_state_e;
    typedef struct packed {
        logic dl_start;
        logic sram_reset;
        logic reg_clear;
        logic io_oe_n;
        logic io_pullup_en;
        logic supply_low_cutoff;
    } pss_out_s;
    localparam pss_out_s OUT_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// ---- core/pss_sync3.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pss_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;
    // A bit changes once the second and third stage agree on it
    always_comb begin
        q_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end
    assign q = q_reg;
endmodule

// ---- core/pss_timer.sv ----
// Loadable down-counter that flags the end of an interval
`timescale 1ns/1ps
module pss_timer #(
    parameter int W = 16,
    parameter int LOAD = 79
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic expired
);
    logic [W-1:0] cnt_reg, cnt_next;
    logic armed_reg, armed_next;
    initial begin
        if (LOAD < 1 || LOAD >= (1 << W)) $error("pss_timer: LOAD does not fit");
    end
    always_comb begin
        cnt_next = cnt_reg;
        armed_next = armed_reg | start;
        if (start) begin
            cnt_next = W'(LOAD);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            armed_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            armed_reg <= armed_next;
        end
    end
    assign expired = armed_reg && cnt_reg == '0 && !start;
endmodule

// ---- core/pss_top.sv ----
// Power-on reset and I/O release sequencer
// How it works
// - I/O tri-stated, pulled up through download
// - Start download at core start threshold
// - Download past configuration time sets late flag
// - No user mode before all banks valid
// - Late banks: user mode 2 us later
// - In user mode watch core only
// - Core sag resets SRAM, tri-states I/O
// - Core recovery restarts download
// - Release registers before I/O tri-states
// - Clear pin holds registers cleared
// - Output-enable pin holds I/O tri-stated
// - Cutoff when any supply low, outputs off
// - Outputs off during supply ramps
// - Outputs off when I/O precedes core
// - Any supply order reaches right state
// - Reconfiguration command tri-states I/O too
`timescale 1ns/1ps
module pss_top #(
    parameter int N_BANKS = pss_pkg::IO_BANKS,
    parameter int CFG_CYCLES = pss_pkg::CONFIGURATION_TIME_CYC,
    parameter int IO_DLY_CYCLES = pss_pkg::IO_DELAY_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Supply comparators and pins
    input wire logic CORE_VALID,
    input wire logic [N_BANKS-1:0] IO_BANK_VALID,
    input wire logic DEVICE_CLEAR_PIN_N,
    input wire logic DEVICE_OUTPUT_ENABLE_PIN,
    // Download engine
    input wire logic DL_DONE,
    output logic DL_START,
    output logic SRAM_RESET,
    // Core and I/O control
    output logic REG_CLEAR,
    output logic IO_OE_N,
    output logic IO_PULLUP_EN,
    output logic SUPPLY_LOW_CUTOFF,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA
);
    localparam int SW = N_BANKS + 3;

    initial begin
        if (N_BANKS < 1) $error("pss_top: N_BANKS must be at least 1");
        if (IO_DLY_CYCLES < 2 || CFG_CYCLES < 2) $error("pss_top: interval too short");
        if (CFG_CYCLES >= (1 << pss_pkg::TIMER_W)) $error("pss_top: configuration time too long");
    end

    logic [SW-1:0] sync_q;
    logic core_v, io_all, clr_pin_n, oe_pin;
    logic cfg_start, cfg_exp, dly_start, dly_exp;
    pss_pkg::pss_state_e st_reg, st_next;
    pss_pkg::pss_out_s out_reg, out_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic reconfig_reg, reconfig_next;
    logic late_reg, late_next;
    logic [31:0] rdata_reg, rdata_next;
    logic user_next;

    // Address match, shared by the read and the write decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = a == ofs;
    endfunction

    // Supplies and both pins come from outside the clock domain
    pss_sync3 #(.W(SW)) u_sync (
        .clk(CLK),
        .rst(RST),
        .d({DEVICE_OUTPUT_ENABLE_PIN, DEVICE_CLEAR_PIN_N, IO_BANK_VALID, CORE_VALID}),
        .q(sync_q)
    );

    assign core_v = sync_q[0];
    assign io_all = &sync_q[N_BANKS:1];
    assign clr_pin_n = sync_q[N_BANKS+1];
    assign oe_pin = sync_q[N_BANKS+2];

    // Configuration time, restarted on every entry into download
    pss_timer #(.W(pss_pkg::TIMER_W), .LOAD(CFG_CYCLES - 1)) u_cfg_tmr (
        .clk(CLK),
        .rst(RST),
        .start(cfg_start),
        .expired(cfg_exp)
    );

    // Late-bank delay, started when the banks come up after the configuration time
    pss_timer #(.W(pss_pkg::TIMER_W), .LOAD(IO_DLY_CYCLES - 1)) u_dly_tmr (
        .clk(CLK),
        .rst(RST),
        .start(dly_start),
        .expired(dly_exp)
    );

    // Sequencer
    always_comb begin
        st_next = st_reg;
        cfg_start = 1'b0;
        dly_start = 1'b0;
        if (!core_v) begin
            st_next = pss_pkg::S_OFF;
        end else begin
            case (st_reg)
                pss_pkg::S_OFF: begin
                    st_next = pss_pkg::S_LOAD;
                    cfg_start = 1'b1;
                end
                pss_pkg::S_LOAD: begin
                    if (DL_DONE) begin
                        st_next = pss_pkg::S_IOWAIT;
                    end
                end
                pss_pkg::S_IOWAIT: begin
                    if (io_all && cfg_exp) begin
                        st_next = pss_pkg::S_IODLY;
                        dly_start = 1'b1;
                    end else if (io_all) begin
                        st_next = pss_pkg::S_REGREL;
                    end
                end
                pss_pkg::S_IODLY: begin
                    if (!io_all) begin
                        st_next = pss_pkg::S_IOWAIT;
                    end else if (dly_exp) begin
                        st_next = pss_pkg::S_REGREL;
                    end
                end
                pss_pkg::S_REGREL: begin
                    st_next = io_all ? pss_pkg::S_USER : pss_pkg::S_IOWAIT;
                end
                pss_pkg::S_USER: begin
                    if (reconfig_reg) begin
                        st_next = pss_pkg::S_LOAD;
                        cfg_start = 1'b1;
                    end
                end
                default: st_next = pss_pkg::S_OFF;
            endcase
        end
    end

    // Registered outputs
    // Computed from the next state so that every pin comes straight from a flop
    always_comb begin
        user_next = st_next == pss_pkg::S_USER;
        out_next.dl_start = st_next == pss_pkg::S_LOAD;
        out_next.sram_reset = st_next == pss_pkg::S_OFF;
        out_next.supply_low_cutoff = !core_v || !io_all;
        out_next.reg_clear = !(user_next || st_next == pss_pkg::S_REGREL)
            || (ctrl_reg[pss_pkg::CTRL_CLR_EN_BIT] && !clr_pin_n);
        out_next.io_oe_n = !user_next || out_next.supply_low_cutoff
            || (ctrl_reg[pss_pkg::CTRL_OE_EN_BIT] && !oe_pin);
        out_next.io_pullup_en = !user_next;
    end

    // Register port
    always_comb begin
        ctrl_next = ctrl_reg;
        reconfig_next = 1'b0;
        late_next = late_reg;
        rdata_next = 32'h0000_0000;
        if (WR && hit(ADDR, pss_pkg::CTRL_OFS)) begin
            ctrl_next = WDATA[1:0];
            reconfig_next = WDATA[pss_pkg::CTRL_RECONFIG_BIT];
        end
        if (WR && hit(ADDR, pss_pkg::STATUS_OFS) && WDATA[pss_pkg::STAT_LATE_BIT]) begin
            late_next = 1'b0;
        end
        // Sticky late flag; a set in the same cycle as a write-one clear wins
        if (st_reg == pss_pkg::S_LOAD && cfg_exp && !DL_DONE) begin
            late_next = 1'b1;
        end
        if (RD && hit(ADDR, pss_pkg::CTRL_OFS)) begin
            rdata_next[1:0] = ctrl_reg;
        end else if (RD && hit(ADDR, pss_pkg::STATUS_OFS)) begin
            rdata_next[pss_pkg::STAT_STATE_LSB +: 3] = st_reg;
            rdata_next[pss_pkg::STAT_CORE_BIT] = core_v;
            rdata_next[pss_pkg::STAT_IO_BIT] = io_all;
            rdata_next[pss_pkg::STAT_LATE_BIT] = late_reg;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg <= pss_pkg::S_OFF;
            out_reg <= pss_pkg::OUT_RESET;
            ctrl_reg <= pss_pkg::CTRL_RESET;
            reconfig_reg <= 1'b0;
            late_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
            out_reg <= out_next;
            ctrl_reg <= ctrl_next;
            reconfig_reg <= reconfig_next;
            late_reg <= late_next;
            rdata_reg <= rdata_next;
        end
    end

    assign DL_START = out_reg.dl_start;
    assign SRAM_RESET = out_reg.sram_reset;
    assign REG_CLEAR = out_reg.reg_clear;
    assign IO_OE_N = out_reg.io_oe_n;
    assign IO_PULLUP_EN = out_reg.io_pullup_en;
    assign SUPPLY_LOW_CUTOFF = out_reg.supply_low_cutoff;
    assign RDATA = rdata_reg;

    // Cycles spent in the late-bank delay
    logic [15:0] dly_h_reg, dly_h_next;
    always_comb begin
        dly_h_next = (st_reg == pss_pkg::S_IODLY) ? dly_h_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dly_h_reg <= 16'h0000;
        end else begin
            dly_h_reg <= dly_h_next;
        end
    end

    // Cycles since the configuration timer was last started
    logic [15:0] cfg_h_reg, cfg_h_next;
    always_comb begin
        cfg_h_next = cfg_start ? 16'h0000 : cfg_h_reg + 16'h0001;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_h_reg <= 16'h0000;
        end else begin
            cfg_h_reg <= cfg_h_next;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    load_tristate_a: assert property (DL_START |-> IO_OE_N && IO_PULLUP_EN)
        else $error("outputs driven during download");
    start_dl_a: assert property ((st_reg == pss_pkg::S_OFF && core_v) |=> DL_START)
        else $error("download not started at core threshold");
    late_flag_a: assert property ((st_reg == pss_pkg::S_LOAD && cfg_exp && !DL_DONE)
        |=> late_reg)
        else $error("late download not flagged");
    io_gate_a: assert property ((!io_all && st_reg != pss_pkg::S_USER)
        |=> st_reg != pss_pkg::S_USER)
        else $error("user mode entered without I/O banks");
    io_delay_a: assert property (
        (st_reg == pss_pkg::S_IODLY && dly_exp && io_all && core_v)
        |-> dly_h_reg == 16'(IO_DLY_CYCLES - 1) ##1 st_reg == pss_pkg::S_REGREL
        ##1 st_reg == pss_pkg::S_USER)
        else $error("late bank delay wrong");
    io_ignored_a: assert property (
        (st_reg == pss_pkg::S_USER && core_v && !reconfig_reg)
        |=> st_reg == pss_pkg::S_USER)
        else $error("user mode left without cause");
    brown_out_a: assert property ((st_reg == pss_pkg::S_USER && !core_v)
        |=> SRAM_RESET && IO_OE_N && IO_PULLUP_EN)
        else $error("brown-out not handled");
    cutoff_off_a: assert property (SUPPLY_LOW_CUTOFF |-> IO_OE_N)
        else $error("cutoff did not force outputs off");
    reg_first_a: assert property (
        ($fell(IO_OE_N) && !ctrl_reg[pss_pkg::CTRL_CLR_EN_BIT])
        |-> !$past(REG_CLEAR))
        else $error("I/O released before registers");
    clr_pin_a: assert property ((ctrl_reg[pss_pkg::CTRL_CLR_EN_BIT] && !clr_pin_n)
        |=> REG_CLEAR)
        else $error("clear pin ignored");
    oe_pin_a: assert property ((ctrl_reg[pss_pkg::CTRL_OE_EN_BIT] && !oe_pin)
        |=> IO_OE_N)
        else $error("output enable pin ignored");
    reconfig_a: assert property ((st_reg == pss_pkg::S_USER && reconfig_reg && core_v)
        |=> DL_START && IO_OE_N && IO_PULLUP_EN)
        else $error("reconfiguration did not tri-state I/O");
    supply_cut_a: assert property ((!core_v || !io_all) |=> SUPPLY_LOW_CUTOFF)
        else $error("cutoff missing while a supply is low");
    early_io_a: assert property ((io_all && !core_v) |=> IO_OE_N && IO_PULLUP_EN)
        else $error("outputs enabled with I/O ahead of core");
    core_loss_a: assert property (!core_v |=> SRAM_RESET && REG_CLEAR && !DL_START)
        else $error("core loss did not reset at once");
    regrel_hold_a: assert property (
        st_reg == pss_pkg::S_REGREL |-> IO_OE_N && IO_PULLUP_EN)
        else $error("I/O released together with registers");
    pullup_hold_a: assert property ((st_reg != pss_pkg::S_USER) |-> IO_PULLUP_EN)
        else $error("pull-ups off outside user mode");
    late_entry_a: assert property (
        (st_reg == pss_pkg::S_IOWAIT && io_all && cfg_exp && core_v)
        |=> st_reg == pss_pkg::S_IODLY)
        else $error("late banks did not start the delay");
    iodly_loss_a: assert property (
        (st_reg == pss_pkg::S_IODLY && !io_all && core_v) |=> st_reg == pss_pkg::S_IOWAIT)
        else $error("bank loss during the delay not handled");
    cfg_span_a: assert property (
        $rose(cfg_exp) |-> cfg_h_reg == 16'(CFG_CYCLES - 1))
        else $error("configuration time miscounted");

    user_reach_c: cover property (st_reg == pss_pkg::S_REGREL ##1 st_reg == pss_pkg::S_USER);
    late_dl_c: cover property (st_reg == pss_pkg::S_LOAD && cfg_exp && !DL_DONE);
    late_bank_c: cover property (st_reg == pss_pkg::S_IODLY && dly_exp);
    brown_out_c: cover property (st_reg == pss_pkg::S_USER && !core_v);
    reconfig_c: cover property (st_reg == pss_pkg::S_USER && reconfig_reg);
endmodule

// ---- testbench/pss_dl_model.sv ----
// Behavioural download engine that answers the sequencer's start request
`timescale 1ns/1ps
module pss_dl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Handshake with the sequencer
    input wire logic start,
    input wire logic [7:0] dly,
    output logic done
);
    logic [7:0] cnt_reg;
    // Done rises dly + 1 cycles into a request and falls as soon as start drops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            done <= 1'b0;
        end else if (!start) begin
            cnt_reg <= 8'h00;
            done <= 1'b0;
        end else if (cnt_reg >= dly) begin
            done <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module testbench;
    localparam int CFG = 40;
    localparam int IODLY = 4;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic CORE_VALID = 1'b0;
    logic [3:0] IO_BANK_VALID = 4'h0;
    logic DEVICE_CLEAR_PIN_N = 1'b0;
    logic DEVICE_OUTPUT_ENABLE_PIN = 1'b0;
    logic DL_DONE;
    logic DL_START, SRAM_RESET, REG_CLEAR, IO_OE_N, IO_PULLUP_EN, SUPPLY_LOW_CUTOFF;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic [7:0] dly = 8'h05;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    pss_top #(.N_BANKS(4), .CFG_CYCLES(CFG), .IO_DLY_CYCLES(IODLY)) i_pss_top (
        .CLK(CLK), .RST(RST), .CORE_VALID(CORE_VALID), .IO_BANK_VALID(IO_BANK_VALID),
        .DEVICE_CLEAR_PIN_N(DEVICE_CLEAR_PIN_N),
        .DEVICE_OUTPUT_ENABLE_PIN(DEVICE_OUTPUT_ENABLE_PIN),
        .DL_DONE(DL_DONE), .DL_START(DL_START), .SRAM_RESET(SRAM_RESET),
        .REG_CLEAR(REG_CLEAR), .IO_OE_N(IO_OE_N), .IO_PULLUP_EN(IO_PULLUP_EN),
        .SUPPLY_LOW_CUTOFF(SUPPLY_LOW_CUTOFF), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA)
    );
    pss_dl_model i_pss_dl_model (
        .clk(CLK), .rst(RST), .start(DL_START), .dly(dly), .done(DL_DONE)
    );

    initial begin
        forever #12.5 CLK = ~CLK;
    end

    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Output vector: start, sram reset, clear, oe_n, pull-up, cutoff
    function automatic logic [31:0] outs();
        return {26'h0000000, DL_START, SRAM_RESET, REG_CLEAR, IO_OE_N, IO_PULLUP_EN,
            SUPPLY_LOW_CUTOFF};
    endfunction

    function automatic logic pick(input int sel);
        case (sel)
            0: return DL_START;
            1: return REG_CLEAR;
            2: return IO_OE_N;
            default: return SRAM_RESET;
        endcase
    endfunction

    // Bounded wait for an output level, n gives the cycles taken
    task automatic wait_for(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (pick(sel) !== v && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk({31'h0, pick(sel)}, {31'h0, v});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp);
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        #1;
        chk(outs(), 32'h1F);
        @(posedge CLK);
        RST <= 1'b0;
        rd(pss_pkg::CTRL_OFS, 32'h0);
        // I/O banks powered before the core
        IO_BANK_VALID <= 4'hF;
        repeat (8) @(posedge CLK);
        #1;
        chk(outs(), 32'h1F);
        CORE_VALID <= 1'b1;
        wait_for(0, 1'b1, 8, n);
        chk(outs(), 32'h2E);
        wait_for(1, 1'b0, CFG, n);
        chk({31'h0, n <= CFG}, 32'h1);
        chk({31'h0, IO_OE_N}, 32'h1);
        @(posedge CLK);
        #1;
        chk(outs(), 32'h0);
        rd(pss_pkg::STATUS_OFS, 32'h35);
        // Bank loss in user mode: cutoff only, state kept
        IO_BANK_VALID <= 4'h7;
        wait_for(2, 1'b1, 8, n);
        rd(pss_pkg::STATUS_OFS, 32'h15);
        chk({31'h0, IO_PULLUP_EN}, 32'h0);
        IO_BANK_VALID <= 4'hF;
        wait_for(2, 1'b0, 8, n);
        // Brown-out, then recovery with late banks
        IO_BANK_VALID <= 4'h0;
        CORE_VALID <= 1'b0;
        wait_for(3, 1'b1, 8, n);
        chk(outs(), 32'h1F);
        CORE_VALID <= 1'b1;
        wait_for(0, 1'b1, 8, n);
        repeat (60) @(posedge CLK);
        #1;
        chk(outs(), 32'h0F);
        IO_BANK_VALID <= 4'hF;
        wait_for(1, 1'b0, 40, n);
        chk({31'h0, n > IODLY && n <= IODLY + 8}, 32'h1);
        chk({31'h0, IO_OE_N}, 32'h1);
        // Reconfiguration with the clear pin option held low
        wr(pss_pkg::CTRL_OFS, 32'h5);
        wait_for(0, 1'b1, 4, n);
        chk(outs(), 32'h2E);
        wait_for(2, 1'b0, 40, n);
        chk({31'h0, REG_CLEAR}, 32'h1);
        DEVICE_CLEAR_PIN_N <= 1'b1;
        wait_for(1, 1'b0, 8, n);
        // Reconfiguration with the output-enable pin option held off
        wr(pss_pkg::CTRL_OFS, 32'h6);
        rd(pss_pkg::CTRL_OFS, 32'h2);
        wait_for(0, 1'b1, 4, n);
        repeat (60) @(posedge CLK);
        #1;
        chk({31'h0, IO_OE_N}, 32'h1);
        rd(pss_pkg::STATUS_OFS, 32'h35);
        DEVICE_OUTPUT_ENABLE_PIN <= 1'b1;
        wait_for(2, 1'b0, 8, n);
        // Download slower than the configuration time sets the late flag
        dly <= 8'h3C;
        wr(pss_pkg::CTRL_OFS, 32'h6);
        wait_for(0, 1'b1, 4, n);
        repeat (80) @(posedge CLK);
        #1;
        chk({31'h0, IO_OE_N}, 32'h0);
        rd(pss_pkg::STATUS_OFS, 32'h75);
        wr(pss_pkg::STATUS_OFS, 32'h40);
        rd(pss_pkg::STATUS_OFS, 32'h35);
        dly <= 8'h05;
        // Unmapped place ignores writes and reads zero
        wr(4'h8, 32'hFFFFFFFF);
        rd(4'h8, 32'h0);
        rd(pss_pkg::CTRL_OFS, 32'h2);
        // Reset in mid-run returns the pins to the safe state
        @(posedge CLK);
        RST <= 1'b1;
        @(posedge CLK);
        #1;
        chk(outs(), 32'h1F);
        // Release again: pins stay safe until the supplies are seen, then restart
        @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        chk(outs(), 32'h1F);
        wait_for(0, 1'b1, 8, n);
        wait_for(2, 1'b0, 40, n);
        summarize();
    end
endmodule
